// ===== hdl/uab_pkg.sv
// constants shared by the auto-baud measurement block
package uab_pkg;
   // register byte offsets
   localparam logic [7:0] UAB_OFF_CTRL = 8'h00;
   localparam logic [7:0] UAB_OFF_STAT = 8'h04;
   localparam logic [7:0] UAB_OFF_DIVL = 8'h08;
   localparam logic [7:0] UAB_OFF_DIVH = 8'h0C;
   localparam logic [7:0] UAB_OFF_RXBUF = 8'h10;
   localparam logic [7:0] UAB_OFF_EVT = 8'h14;
   localparam logic [7:0] UAB_OFF_MASK = 8'h18;
   // control register bit positions
   localparam int UAB_CTL_EN = 0;
   localparam int UAB_CTL_WIDE = 1;
   localparam int UAB_CTL_HS = 2;
   localparam int UAB_CTL_WAKE = 3;
   // status register bit positions
   localparam int UAB_ST_IDLE = 0;
   localparam int UAB_ST_MEAS = 1;
   // event register bit positions
   localparam int UAB_EV_RX = 0;
   localparam int UAB_EV_OVF = 1;
   localparam int UAB_EV_W = 2;
   // measurement clock: fosc/512, fosc/128, fosc/32 as prescaler masks
   localparam int UAB_PRE_W = 9;
   localparam logic [8:0] UAB_MASK_SLOW = 9'h1FF;
   localparam logic [8:0] UAB_MASK_MID = 9'h07F;
   localparam logic [8:0] UAB_MASK_FAST = 9'h01F;
   // counter start value and rising edges counted before the last of a sync character
   localparam logic [15:0] UAB_CNT_START = 16'h0001;
   localparam logic [15:0] UAB_CNT_MAX = 16'hFFFF;
   localparam logic [2:0] UAB_LAST_EDGE = 3'h4;
   localparam logic [31:0] UAB_RXBUF_VAL = 32'h0000_0000;
   typedef enum logic [2:0] {
      UAB_IDLE, UAB_WAKE_FALL, UAB_WAKE_RISE, UAB_WAIT_START, UAB_WAIT_RISE1, UAB_COUNT
   } uab_state_t;
endpackage

// ===== hdl/uab_rx_sync.sv
// receive line synchroniser with filtered level and edge pulses
`timescale 1ns/10ps
module uab_rx_sync (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic rx_pin, // receive line from the pin
   output logic rx_rise, // one-cycle pulse on a rising edge
   output logic rx_fall // one-cycle pulse on a falling edge
);
   logic s1_ff, s2_ff, s3_ff, lvl_ff;
   logic nxt_lvl;

   // level changes only once the last two stages agree
   always_comb begin
      nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
   end

   // three-stage chain and filtered level, line idles high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         lvl_ff <= 1'b1;
      end else begin
         s1_ff <= rx_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   assign rx_rise = nxt_lvl & ~lvl_ff;
   assign rx_fall = ~nxt_lvl & lvl_ff;
endmodule

// ===== hdl/uab_autobaud.sv
// auto-baud measurement logic with apb register access
//
// Summary of operation
// - In measurement mode receive line edges gate the divisor counter instead of the reverse.
// - Setting autobaud_enable starts calibration and holds the receiver idle until done.
// - Counting starts on the first rising edge after the start bit.
// - The fifth rising edge stops counting, keeps the count, clears the enable, sets the flag.
// - Reading the receive buffer clears receive_flag; software discards the value.
// - Both divisor bytes form one 16-bit counter whatever wide_divisor_select says.
// - The counter advances once per tick of the selected measurement clock, with no further division.
// - The two select bits choose a measurement clock of fosc/512, fosc/128 or fosc/32.
// - The count begins at one; software subtracts one for best accuracy.
// - With wake_on_break_enable set the break is skipped and the next character measured.
// - Counter overflow sets autobaud_overflow and receive_flag, and counting goes on.
// - receive_idle stays low during calibration and is set on the fifth rising edge.
`timescale 1ns/10ps
module uab_autobaud
   import uab_pkg::*;
(
   input wire logic pclk, // system clock, 125 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic rx_pin, // receive line
   output logic irq, // level interrupt
   output logic rx_hold_idle, // receive state machine held idle
   output logic [15:0] rate_divisor // divisor for normal reception
);
   uab_state_t state_ff, nxt_state;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [2:0] edges_ff, nxt_edges;
   logic [8:0] presc_ff, nxt_presc;
   logic en_ff, nxt_en, wide_ff, nxt_wide, hs_ff, nxt_hs, wake_ff, nxt_wake;
   logic rflag_ff, nxt_rflag, ovf_ff, nxt_ovf, wflag_ff, nxt_wflag;
   logic idle_ff, nxt_idle, hold_ff, nxt_hold;
   logic [2:0] mask_ff, nxt_mask;
   logic pready_ff, nxt_pready, perr_ff, nxt_perr, irq_ff, nxt_irq;
   logic [31:0] prdata_ff, nxt_prdata;
   logic rx_rise, rx_fall, tick, take, wr, rd, mapped, busy;
   logic set_rx, set_ovf, set_w;

   // measurement clock mask from the two select bits
   function automatic logic [8:0] abd_mask(input logic wide, input logic hs);
      logic [8:0] m;
      m = UAB_MASK_MID;
      if (!wide && !hs) begin
         m = UAB_MASK_SLOW;
      end else if (wide && hs) begin
         m = UAB_MASK_FAST;
      end
      return m;
   endfunction

   uab_rx_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .rx_pin(rx_pin),
      .rx_rise(rx_rise),
      .rx_fall(rx_fall)
   );

   // apb access decode
   assign take = psel & penable & pready_ff;
   assign wr = take & pwrite;
   assign rd = take & ~pwrite;
   assign mapped = (paddr == UAB_OFF_CTRL) || (paddr == UAB_OFF_STAT) ||
      (paddr == UAB_OFF_DIVL) || (paddr == UAB_OFF_DIVH) || (paddr == UAB_OFF_RXBUF) ||
      (paddr == UAB_OFF_EVT) || (paddr == UAB_OFF_MASK);
   assign busy = (state_ff != UAB_IDLE);
   assign tick = ((presc_ff & abd_mask(wide_ff, hs_ff)) == abd_mask(wide_ff, hs_ff));

   // measurement sequence, control and event flags
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_edges = edges_ff;
      nxt_presc = presc_ff + 9'h001;
      nxt_en = en_ff;
      nxt_wide = wide_ff;
      nxt_hs = hs_ff;
      nxt_wake = wake_ff;
      nxt_idle = idle_ff;
      nxt_mask = mask_ff;
      set_rx = 1'b0;
      set_ovf = 1'b0;
      set_w = 1'b0;
      if (wr && paddr == UAB_OFF_CTRL) begin
         nxt_en = pwdata[UAB_CTL_EN];
         nxt_wide = pwdata[UAB_CTL_WIDE];
         nxt_hs = pwdata[UAB_CTL_HS];
         nxt_wake = pwdata[UAB_CTL_WAKE];
         if (pwdata[UAB_CTL_EN] && !busy) begin
            nxt_idle = 1'b0;
            nxt_state = pwdata[UAB_CTL_WAKE] ? UAB_WAKE_FALL : UAB_WAIT_START;
         end else if (!pwdata[UAB_CTL_EN] && busy) begin
            nxt_idle = 1'b1;
            nxt_state = UAB_IDLE;
         end
      end
      if (wr && !busy && paddr == UAB_OFF_DIVL) begin
         nxt_cnt[7:0] = pwdata[7:0];
      end
      if (wr && !busy && paddr == UAB_OFF_DIVH) begin
         nxt_cnt[15:8] = pwdata[7:0];
      end
      if (wr && paddr == UAB_OFF_MASK) begin
         nxt_mask = pwdata[2:0];
      end
      case (state_ff)
         UAB_IDLE: begin
         end
         UAB_WAKE_FALL: begin
            if (rx_fall) begin
               set_w = 1'b1;
               nxt_state = UAB_WAKE_RISE;
            end
         end
         UAB_WAKE_RISE: begin
            // break over: skip it and measure the next character
            if (rx_rise) begin
               nxt_wake = 1'b0;
               nxt_state = UAB_WAIT_START;
            end
         end
         UAB_WAIT_START: begin
            if (rx_fall) begin
               nxt_state = UAB_WAIT_RISE1;
            end
         end
         UAB_WAIT_RISE1: begin
            // first rising edge after the start bit opens the gate
            if (rx_rise) begin
               nxt_cnt = UAB_CNT_START;
               nxt_edges = 3'h1;
               nxt_presc = '0;
               nxt_state = UAB_COUNT;
            end
         end
         UAB_COUNT: begin
            if (tick) begin
               nxt_cnt = cnt_ff + 16'h0001;
               if (cnt_ff == UAB_CNT_MAX) begin
                  set_ovf = 1'b1;
                  set_rx = 1'b1;
               end
            end
            if (rx_rise) begin
               if (edges_ff == UAB_LAST_EDGE) begin
                  nxt_cnt = cnt_ff;
                  nxt_en = 1'b0;
                  nxt_idle = 1'b1;
                  set_rx = 1'b1;
                  nxt_state = UAB_IDLE;
               end else begin
                  nxt_edges = edges_ff + 3'h1;
               end
            end
         end
         default: begin
            nxt_state = UAB_IDLE;
         end
      endcase
   end

   // sticky events: set wins over clear
   always_comb begin
      nxt_rflag = (rflag_ff & ~((rd && paddr == UAB_OFF_RXBUF) ||
         (wr && paddr == UAB_OFF_EVT && pwdata[UAB_EV_RX]))) | set_rx;
      nxt_ovf = (ovf_ff & ~(wr && paddr == UAB_OFF_EVT && pwdata[UAB_EV_OVF])) | set_ovf;
      nxt_wflag = (wflag_ff & ~(wr && paddr == UAB_OFF_EVT && pwdata[UAB_EV_W])) | set_w;
      nxt_irq = |({wflag_ff, ovf_ff, rflag_ff} & mask_ff);
      nxt_hold = ~nxt_idle;
   end

   // apb answer: one wait state, read data and error
   always_comb begin
      nxt_pready = psel & penable & ~pready_ff;
      nxt_perr = psel & penable & ~pready_ff & ~mapped;
      nxt_prdata = prdata_ff;
      if (psel && penable && !pready_ff) begin
         nxt_prdata = '0;
         case (paddr)
            UAB_OFF_CTRL: begin
               nxt_prdata[UAB_CTL_EN] = en_ff;
               nxt_prdata[UAB_CTL_WIDE] = wide_ff;
               nxt_prdata[UAB_CTL_HS] = hs_ff;
               nxt_prdata[UAB_CTL_WAKE] = wake_ff;
            end
            UAB_OFF_STAT: begin
               nxt_prdata[UAB_ST_IDLE] = idle_ff;
               nxt_prdata[UAB_ST_MEAS] = busy;
            end
            UAB_OFF_DIVL: nxt_prdata[7:0] = cnt_ff[7:0];
            UAB_OFF_DIVH: nxt_prdata[7:0] = cnt_ff[15:8];
            UAB_OFF_RXBUF: nxt_prdata = UAB_RXBUF_VAL;
            UAB_OFF_EVT: begin
               nxt_prdata[UAB_EV_RX] = rflag_ff;
               nxt_prdata[UAB_EV_OVF] = ovf_ff;
               nxt_prdata[UAB_EV_W] = wflag_ff;
            end
            UAB_OFF_MASK: nxt_prdata[2:0] = mask_ff;
            default: nxt_prdata = '0;
         endcase
      end
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= UAB_IDLE;
         cnt_ff <= '0;
         edges_ff <= '0;
         presc_ff <= '0;
         en_ff <= 1'b0;
         wide_ff <= 1'b0;
         hs_ff <= 1'b0;
         wake_ff <= 1'b0;
         idle_ff <= 1'b1;
         hold_ff <= 1'b0;
         mask_ff <= '0;
         rflag_ff <= 1'b0;
         ovf_ff <= 1'b0;
         wflag_ff <= 1'b0;
         irq_ff <= 1'b0;
         pready_ff <= 1'b0;
         perr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         edges_ff <= nxt_edges;
         presc_ff <= nxt_presc;
         en_ff <= nxt_en;
         wide_ff <= nxt_wide;
         hs_ff <= nxt_hs;
         wake_ff <= nxt_wake;
         idle_ff <= nxt_idle;
         hold_ff <= nxt_hold;
         mask_ff <= nxt_mask;
         rflag_ff <= nxt_rflag;
         ovf_ff <= nxt_ovf;
         wflag_ff <= nxt_wflag;
         irq_ff <= nxt_irq;
         pready_ff <= nxt_pready;
         perr_ff <= nxt_perr;
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = perr_ff;
   assign irq = irq_ff;
   assign rx_hold_idle = hold_ff;
   assign rate_divisor = cnt_ff;

   // helper: cycles between measurement ticks while settings are unchanged
   logic [8:0] gap_ff;
   logic gap_ok_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff <= '0;
         gap_ok_ff <= 1'b0;
      end else begin
         gap_ff <= (tick || nxt_presc == '0) ? '0 : gap_ff + 9'h001;
         gap_ok_ff <= (wr && paddr == UAB_OFF_CTRL) ? 1'b0 :
            ((tick || nxt_presc == '0) ? 1'b1 : gap_ok_ff);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_last_rise;
      state_ff == UAB_COUNT && rx_rise && edges_ff == UAB_LAST_EDGE;
   endsequence
   sequence s_done;
      !en_ff && rflag_ff && idle_ff && state_ff == UAB_IDLE;
   endsequence

   arm_holds_a: assert property ($rose(busy) |-> rx_hold_idle && !idle_ff)
      else $error("receiver not held idle at arm");
   gate_closed_a: assert property (state_ff == UAB_WAIT_START && !wr |=> $stable(cnt_ff))
      else $error("counter moved before first rising edge");
   first_edge_a: assert property (state_ff == UAB_WAIT_RISE1 && rx_rise && !(wr && paddr ==
      UAB_OFF_CTRL) |=> state_ff == UAB_COUNT && cnt_ff == 16'h0001)
      else $error("count did not start at one");
   fifth_edge_a: assert property (s_last_rise and !wr |=> s_done ##1 !rx_hold_idle)
      else $error("fifth rising edge did not finish calibration");
   rxbuf_clear_a: assert property (rd && paddr == UAB_OFF_RXBUF && !set_rx |=> !rflag_ff)
      else $error("receive buffer read did not clear flag");
   wide_count_a: assert property (state_ff == UAB_COUNT && tick && !rx_rise |=>
      cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not advance as 16 bits");
   slow_rate_a: assert property (state_ff == UAB_COUNT && !tick && !rx_rise |=> $stable(cnt_ff))
      else $error("counter advanced without a measurement tick");
   tick_gap_a: assert property (tick && gap_ok_ff |-> gap_ff == abd_mask(wide_ff, hs_ff))
      else $error("measurement clock period wrong");
   overflow_a: assert property (state_ff == UAB_COUNT && tick && cnt_ff == UAB_CNT_MAX &&
      !rx_rise |=> ovf_ff && rflag_ff && state_ff == UAB_COUNT)
      else $error("overflow not flagged or counting stopped");
   break_skip_a: assert property (state_ff == UAB_WAKE_RISE && rx_rise && !wr |=>
      state_ff == UAB_WAIT_START && !wake_ff)
      else $error("break not skipped");
   irq_level_a: assert property (irq == $past(|({wflag_ff, ovf_ff, rflag_ff} & mask_ff)))
      else $error("interrupt output wrong");
endmodule

// ===== verif/uab_remote_tx.sv
// remote serial sender model that transmits the sync character
`timescale 1ns/10ps
module uab_remote_tx (
   input wire logic pclk, // system clock of the bench
   output logic txd // serial line towards the receiver
);
   // line idles high, as on a pulled-up serial link
   initial begin
      txd = 1'b1;
   end

   // one bit on the line for len clock cycles, changed just after an edge
   task automatic put_bit(input logic b, input int len);
      @(posedge pclk);
      txd <= b;
      repeat (len - 1) @(posedge pclk);
   endtask

   // optional all-zero break with its stop bit, then 55h lsb first, 8n1
   task automatic send_sync(input int len, input bit brk);
      logic [9:0] frame;
      frame = {1'b1, 8'h55, 1'b0};
      if (brk) begin
         repeat (13) put_bit(1'b0, len);
         put_bit(1'b1, len);
      end
      for (int i = 0; i < 10; i++) begin
         put_bit(frame[i], len);
      end
      repeat (len) @(posedge pclk);
   endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the auto-baud measurement block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import uab_pkg::*;
   localparam int LIMIT = 80000; // ceiling on run length in cycles
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_pin;
   logic irq;
   logic rx_hold_idle;
   logic [15:0] rate_divisor;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   uab_autobaud uab_autobaud_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq),
      .rx_hold_idle(rx_hold_idle), .rate_divisor(rate_divisor));
   uab_remote_tx uab_remote_tx_inst (.pclk(pclk), .txd(rx_pin));

   // clock at 125 MHz
   always #4 pclk = ~pclk;

   // verdict and end of run
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         conclude();
      end
   end

   // one apb transfer; data and error taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // register read and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask

   // register values out of reset and an unmapped access
   task automatic t_reset();
      `CHK("irq", 1'b0, irq)
      `CHK("hold", 1'b0, rx_hold_idle)
      rchk(UAB_OFF_CTRL, 32'h0, "ctrl");
      rchk(UAB_OFF_STAT, 32'h1, "stat");
      rchk(UAB_OFF_EVT, 32'h0, "evt");
      rchk(UAB_OFF_MASK, 32'h0, "mask");
      rchk(8'h1C, 32'h0, "unmapped");
      `CHK("slverr", 1'b1, err)
   endtask

   // arm, send sync at 8 bit times of k ticks plus half a tick, check result
   task automatic t_measure(input logic wide, input logic hs, input logic brk, input int k);
      int m;
      logic [15:0] cnt;
      m = (wide & hs) ? 32 : ((wide | hs) ? 128 : 512);
      cnt = 16'(k + 1);
      apb(1'b1, UAB_OFF_MASK, 32'h1);
      apb(1'b1, UAB_OFF_CTRL, {28'h0, brk, hs, wide, 1'b1});
      rchk(UAB_OFF_STAT, 32'h2, "stat busy");
      `CHK("hold busy", 1'b1, rx_hold_idle)
      uab_remote_tx_inst.send_sync((2 * k + 1) * m / 16, brk);
      `CHK("irq done", 1'b1, irq)
      rchk(UAB_OFF_CTRL, {28'h0, 1'b0, hs, wide, 1'b0}, "ctrl done");
      rchk(UAB_OFF_DIVL, {24'h0, cnt[7:0]}, "divl");
      rchk(UAB_OFF_DIVH, {24'h0, cnt[15:8]}, "divh");
      rchk(UAB_OFF_EVT, {29'h0, brk, 2'b01}, "evt");
      rchk(UAB_OFF_STAT, 32'h1, "stat done");
      `CHK("divisor", cnt, rate_divisor)
      `CHK("hold done", 1'b0, rx_hold_idle)
      apb(1'b1, UAB_OFF_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, UAB_OFF_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK("irq unmasked", 1'b1, irq)
      rchk(UAB_OFF_RXBUF, 32'h0, "rxbuf");
      apb(1'b1, UAB_OFF_EVT, 32'h4);
      rchk(UAB_OFF_EVT, 32'h0, "evt clear");
      `CHK("irq clear", 1'b0, irq)
   endtask

   // divisor written by software drives normal reception
   task automatic t_divisor();
      apb(1'b1, UAB_OFF_DIVL, 32'h34);
      apb(1'b1, UAB_OFF_DIVH, 32'h12);
      @(posedge pclk);
      `CHK("divisor sw", 16'h1234, rate_divisor)
   endtask

   // divisor writes ignored while armed, clearing the enable abandons calibration
   task automatic t_abort();
      apb(1'b1, UAB_OFF_CTRL, 32'h7);
      rchk(UAB_OFF_STAT, 32'h2, "stat armed");
      apb(1'b1, UAB_OFF_DIVL, 32'h55);
      rchk(UAB_OFF_DIVL, 32'h34, "divl armed");
      apb(1'b1, UAB_OFF_CTRL, 32'h6);
      rchk(UAB_OFF_STAT, 32'h1, "stat abort");
      `CHK("hold abort", 1'b0, rx_hold_idle)
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_measure(1'b0, 1'b0, 1'b0, 10);
      t_measure(1'b1, 1'b0, 1'b1, 10);
      t_measure(1'b0, 1'b1, 1'b0, 256);
      t_measure(1'b1, 1'b1, 1'b0, 10);
      t_divisor();
      t_abort();
      conclude();
   end
endmodule
